// *** crse_map.vh ***
// constants for the return and shift execution slice
`ifndef CRSE_MAP_VH
`define CRSE_MAP_VH

// general register geometry
`define CRSE_XLEN 32
`define CRSE_NREG 16
`define CRSE_SP_IDX 4'hF

// whole-word opcodes
`define CRSE_OP_EXC_RET 16'h002B
`define CRSE_OP_SUB_RET 16'h000B
`define CRSE_OP_SET_FLAG 16'h0018

// shift group: top nibble and low byte, register number in bits 11..8
`define CRSE_SH_GROUP 4'h4
`define CRSE_SH_ARITH_L1 8'h20
`define CRSE_SH_LOGIC_L1 8'h00
`define CRSE_SH_ARITH_R1 8'h21
`define CRSE_SH_LOGIC_R1 8'h01
`define CRSE_SH_LOGIC_L2 8'h08
`define CRSE_SH_LOGIC_L8 8'h18
`define CRSE_SH_LOGIC_L16 8'h28

// other branch encodings seen in a delay slot
`define CRSE_BR_IND_CALL 8'h0B
`define CRSE_BR_IND_JUMP 8'h2B
`define CRSE_BR_REL_JUMP 4'hA
`define CRSE_BR_REL_CALL 4'hB
`define CRSE_BR_COND_HI 4'h8
`define CRSE_BR_COND_T 4'h9
`define CRSE_BR_COND_F 4'hB

// shifter operation codes
`define CRSE_SOP_NONE 3'h0
`define CRSE_SOP_L1 3'h1
`define CRSE_SOP_AR1 3'h2
`define CRSE_SOP_LR1 3'h3
`define CRSE_SOP_L2 3'h4
`define CRSE_SOP_L8 3'h5
`define CRSE_SOP_L16 3'h6

// status word
`define CRSE_STATUS_MASK 32'h000003F3
`define CRSE_T_BIT 0

// stack and fetch steps
`define CRSE_STACK_STEP 32'h00000004
`define CRSE_INSTR_STEP 32'h00000002

// reset values
`define CRSE_PC_RST 32'h00000000
`define CRSE_STATUS_RST 32'h00000000
`define CRSE_REG_RST 32'h00000000

`endif

// *** crse_shift.v ***
// single-cycle shifter for the shift group
`timescale 1ns/1ns
`include "crse_map.vh"

module crse_shift (
    // operation select
    input wire [2:0] op_i,
    // operand to be shifted
    input wire [31:0] val_i,
    // result, new flag and flag write
    output reg [31:0] res_o,
    output reg t_o,
    output reg t_we_o
);

    // pure combinational shift, flag written only by single-bit forms
    always @* begin
        res_o = val_i;
        t_o = 1'b0;
        t_we_o = 1'b0;
        case (op_i)
            `CRSE_SOP_L1: begin
                // zero into bit 0, old top bit to flag
                res_o = {val_i[30:0], 1'b0};
                t_o = val_i[31];
                t_we_o = 1'b1;
            end
            `CRSE_SOP_AR1: begin
                // sign kept, old bit 0 to flag
                res_o = {val_i[31], val_i[31:1]};
                t_o = val_i[0];
                t_we_o = 1'b1;
            end
            `CRSE_SOP_LR1: begin
                // zero into top bit, old bit 0 to flag
                res_o = {1'b0, val_i[31:1]};
                t_o = val_i[0];
                t_we_o = 1'b1;
            end
            // multi-bit forms drop shifted-out bits, flag untouched
            `CRSE_SOP_L2: res_o = {val_i[29:0], 2'h0};
            `CRSE_SOP_L8: res_o = {val_i[23:0], 8'h00};
            `CRSE_SOP_L16: res_o = {val_i[15:0], 16'h0000};
            default: res_o = val_i;
        endcase
    end

endmodule // crse_shift

// *** crse_top.v ***
// return and shift execution slice of the cpu
`timescale 1ns/1ns
`include "crse_map.vh"

module crse_top (
    // clock and synchronous active-low reset
    input wire clk_sys_i,
    input wire rstn_i,
    // instruction issue from the fetch stage
    input wire issue_valid_i,
    input wire [15:0] issue_instr_i,
    output reg issue_ready_o,
    // stack read port toward the memory system
    output reg stk_req_o,
    output reg [31:0] stk_addr_o,
    input wire stk_ack_i,
    input wire [31:0] stk_data_i,
    // register preload from the rest of the cpu
    input wire gpr_ld_en_i,
    input wire [3:0] gpr_ld_idx_i,
    input wire [31:0] gpr_ld_data_i,
    input wire link_ld_en_i,
    input wire [31:0] link_ld_data_i,
    // program flow and status
    output reg [31:0] pc_o,
    output reg [31:0] status_word_o,
    output reg branch_o,
    output reg illegal_slot_o,
    output reg exc_block_o,
    // register write-back mirror
    output reg wb_en_o,
    output reg [3:0] wb_idx_o,
    output reg [31:0] wb_data_o
);

    // sequencer states
    localparam ST_IDLE = 3'h0;
    localparam ST_POP_PC = 3'h1;
    localparam ST_POP_STATUS = 3'h2;
    localparam ST_FIN = 3'h3;
    localparam ST_LINK_WAIT = 3'h4;
    localparam ST_SLOT = 3'h5;

    // state and architectural registers
    reg [2:0] state_ff; // sequencer state
    reg [2:0] nxt_state; // next state
    reg [31:0] pc_ff; // next fetch address
    reg [31:0] status_word_ff; // status word, t in bit 0
    reg [31:0] procedure_link_reg_ff; // subroutine return address
    reg [31:0] target_ff; // latched branch destination
    reg [31:0] nxt_target; // next destination

    // decode results
    wire take; // instruction accepted this cycle
    wire [3:0] rn; // register field
    wire in_slot; // accepting the delay-slot instruction
    reg is_exc_ret; // exception return
    reg is_sub_ret; // subroutine return
    reg is_set_flag; // set t
    reg is_branch; // any branch encoding
    reg [2:0] sh_op; // shifter operation

    // execute write port
    reg ex_we; // general register write
    reg [3:0] ex_idx; // written register
    reg [31:0] ex_data; // written value
    reg ex_t_we; // flag write
    reg ex_t; // flag value
    reg status_load; // status word restore from stack
    reg branch_now; // redirect after slot instruction
    reg illegal_now; // branch found in slot

    // shifter connection
    wire [31:0] sh_res; // shift result
    wire sh_t; // shift flag
    wire sh_t_we; // shift writes flag
    wire [31:0] gpr_rd [0:15]; // register read view
    wire [31:0] sp_val; // current stack pointer

    assign take = issue_valid_i & issue_ready_o;
    assign rn = issue_instr_i[11:8];
    assign in_slot = (state_ff == ST_SLOT);
    assign sp_val = gpr_rd[`CRSE_SP_IDX];

    // register bank, one 32-bit flop word per entry
    genvar gi;
    generate
        for (gi = 0; gi < `CRSE_NREG; gi = gi + 1) begin : gen_gpr
            reg [31:0] q_ff; // register content
            assign gpr_rd[gi] = q_ff;
            // execute write wins over preload
            always @(posedge clk_sys_i) begin
                if (!rstn_i) begin
                    q_ff <= `CRSE_REG_RST;
                end else if (ex_we && (ex_idx == gi)) begin
                    q_ff <= ex_data;
                end else if (gpr_ld_en_i && (gpr_ld_idx_i == gi)) begin
                    q_ff <= gpr_ld_data_i;
                end
            end
        end
    endgenerate

    // shifter instance
    crse_shift u_shift (
        .op_i(sh_op),
        .val_i(gpr_rd[rn]),
        .res_o(sh_res),
        .t_o(sh_t),
        .t_we_o(sh_t_we)
    );

    // opcode decode of the issued instruction
    always @* begin
        is_exc_ret = (issue_instr_i == `CRSE_OP_EXC_RET);
        is_sub_ret = (issue_instr_i == `CRSE_OP_SUB_RET);
        is_set_flag = (issue_instr_i == `CRSE_OP_SET_FLAG);
        sh_op = `CRSE_SOP_NONE;
        if (issue_instr_i[15:12] == `CRSE_SH_GROUP) begin
            case (issue_instr_i[7:0])
                `CRSE_SH_ARITH_L1: sh_op = `CRSE_SOP_L1;
                `CRSE_SH_LOGIC_L1: sh_op = `CRSE_SOP_L1;
                `CRSE_SH_ARITH_R1: sh_op = `CRSE_SOP_AR1;
                `CRSE_SH_LOGIC_R1: sh_op = `CRSE_SOP_LR1;
                `CRSE_SH_LOGIC_L2: sh_op = `CRSE_SOP_L2;
                `CRSE_SH_LOGIC_L8: sh_op = `CRSE_SOP_L8;
                `CRSE_SH_LOGIC_L16: sh_op = `CRSE_SOP_L16;
                default: sh_op = `CRSE_SOP_NONE;
            endcase
        end
        // returns, indirect calls and jumps, relative and conditional branches
        is_branch = is_exc_ret | is_sub_ret
            | ((issue_instr_i[15:12] == `CRSE_SH_GROUP)
               && ((issue_instr_i[7:0] == `CRSE_BR_IND_CALL)
                   || (issue_instr_i[7:0] == `CRSE_BR_IND_JUMP)))
            | (issue_instr_i[15:12] == `CRSE_BR_REL_JUMP)
            | (issue_instr_i[15:12] == `CRSE_BR_REL_CALL)
            | ((issue_instr_i[15:12] == `CRSE_BR_COND_HI)
               && ((issue_instr_i[11:8] == `CRSE_BR_COND_T)
                   || (issue_instr_i[11:8] == `CRSE_BR_COND_F)));
    end

    // sequencer and execute write selection
    always @* begin
        nxt_state = state_ff;
        nxt_target = target_ff;
        ex_we = 1'b0;
        ex_idx = rn;
        ex_data = sh_res;
        ex_t_we = 1'b0;
        ex_t = 1'b0;
        status_load = 1'b0;
        branch_now = 1'b0;
        illegal_now = 1'b0;
        case (state_ff)
            ST_IDLE, ST_SLOT: begin
                if (take && in_slot && is_branch) begin
                    // slot branch is refused and not executed
                    illegal_now = 1'b1;
                    nxt_state = ST_IDLE;
                end else if (take) begin
                    // single-state operations, also legal in a slot
                    if (sh_op != `CRSE_SOP_NONE) begin
                        ex_we = 1'b1;
                        ex_t_we = sh_t_we;
                        ex_t = sh_t;
                    end else if (is_set_flag) begin
                        // only the flag changes
                        ex_t_we = 1'b1;
                        ex_t = 1'b1;
                    end
                    if (in_slot) begin
                        // redirect once the slot instruction is done
                        branch_now = 1'b1;
                        nxt_state = ST_IDLE;
                    end else if (is_exc_ret) begin
                        nxt_state = ST_POP_PC; // state 2 of 4
                    end else if (is_sub_ret) begin
                        // link value captured before any slot write
                        nxt_target = procedure_link_reg_ff;
                        nxt_state = ST_LINK_WAIT;
                    end
                end
            end
            ST_POP_PC: begin
                if (stk_ack_i) begin
                    // restored pc, then bump stack pointer
                    nxt_target = stk_data_i;
                    ex_we = 1'b1;
                    ex_idx = `CRSE_SP_IDX;
                    ex_data = sp_val + `CRSE_STACK_STEP;
                    nxt_state = ST_POP_STATUS;
                end
            end
            ST_POP_STATUS: begin
                if (stk_ack_i) begin
                    // masked status word, bump stack pointer again
                    status_load = 1'b1;
                    ex_we = 1'b1;
                    ex_idx = `CRSE_SP_IDX;
                    ex_data = sp_val + `CRSE_STACK_STEP;
                    nxt_state = ST_FIN;
                end
            end
            ST_FIN: nxt_state = ST_SLOT; // state 4 of 4
            ST_LINK_WAIT: nxt_state = ST_SLOT; // state 2 of 2
            default: nxt_state = ST_IDLE;
        endcase
    end

    // state, flow and status registers
    always @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            state_ff <= ST_IDLE;
            pc_ff <= `CRSE_PC_RST;
            status_word_ff <= `CRSE_STATUS_RST;
            procedure_link_reg_ff <= `CRSE_REG_RST;
            target_ff <= `CRSE_REG_RST;
        end else begin
            state_ff <= nxt_state;
            target_ff <= nxt_target;
            // resume at the restored or linked address
            if (branch_now) begin
                pc_ff <= target_ff;
            end else if (take && !illegal_now) begin
                pc_ff <= pc_ff + `CRSE_INSTR_STEP;
            end
            // status restore from the stack, else flag update
            if (status_load) begin
                status_word_ff <= stk_data_i & `CRSE_STATUS_MASK;
            end else if (ex_t_we) begin
                status_word_ff[`CRSE_T_BIT] <= ex_t;
            end
            // link register preload
            if (link_ld_en_i) begin
                procedure_link_reg_ff <= link_ld_data_i;
            end
        end
    end

    // registered outputs; ready, stack request and exception block from the next state
    always @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            issue_ready_o <= 1'b0;
            stk_req_o <= 1'b0;
            stk_addr_o <= `CRSE_REG_RST;
            pc_o <= `CRSE_PC_RST;
            status_word_o <= `CRSE_STATUS_RST;
            branch_o <= 1'b0;
            illegal_slot_o <= 1'b0;
            exc_block_o <= 1'b0;
            wb_en_o <= 1'b0;
            wb_idx_o <= 4'h0;
            wb_data_o <= `CRSE_REG_RST;
        end else begin
            issue_ready_o <= (nxt_state == ST_IDLE) || (nxt_state == ST_SLOT);
            // stack request held across both pops
            stk_req_o <= (nxt_state == ST_POP_PC) || (nxt_state == ST_POP_STATUS);
            if (state_ff != ST_POP_PC && nxt_state == ST_POP_PC) begin
                stk_addr_o <= sp_val; // pc at stack top
            end else if (state_ff == ST_POP_PC && nxt_state == ST_POP_STATUS) begin
                stk_addr_o <= sp_val + `CRSE_STACK_STEP;
            end
            // exceptions and interrupts held off until slot done
            exc_block_o <= (nxt_state != ST_IDLE);
            pc_o <= branch_now ? target_ff
                : ((take && !illegal_now) ? pc_ff + `CRSE_INSTR_STEP : pc_ff);
            status_word_o <= status_load ? (stk_data_i & `CRSE_STATUS_MASK)
                : (ex_t_we ? {status_word_ff[31:1], ex_t} : status_word_ff);
            branch_o <= branch_now;
            illegal_slot_o <= illegal_now;
            wb_en_o <= ex_we;
            wb_idx_o <= ex_idx;
            wb_data_o <= ex_data;
        end
    end

endmodule // crse_top

// *** crse_stack_model.sv ***
// stack memory model answering the slice's stack reads
`timescale 1ns/1ns
module crse_stack_model (
    // clock
    input wire clk_sys_i,
    // stack read request, answer delay and answer
    input wire req_i,
    input wire [31:0] addr_i,
    input wire [3:0] wait_i,
    output reg ack_o,
    output reg [31:0] data_o
);
    reg [3:0] cnt_ff; // idle cycles before the answer
    initial begin
        ack_o = 1'b0;
        data_o = 32'h00000000;
        cnt_ff = 4'h0;
    end
    // answer after wait_i cycles; data scrambled outside the ack cycle
    always @(posedge clk_sys_i) begin
        ack_o <= 1'b0;
        data_o <= ~data_o;
        if (req_i && !ack_o) begin
            if (cnt_ff == wait_i) begin
                ack_o <= 1'b1;
                data_o <= addr_i ^ 32'hA5A5F3FF;
                cnt_ff <= 4'h0;
            end else begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end
endmodule // crse_stack_model

// *** crse_top_sva.sv ***
// port checker for the return and shift slice
`timescale 1ns/1ns
`include "crse_map.vh"
module crse_top_sva (
    // clock and reset
    input wire clk_sys_i,
    input wire rstn_i,
    // issue and stack
    input wire issue_valid_i,
    input wire [15:0] issue_instr_i,
    input wire issue_ready_o,
    input wire stk_req_o,
    input wire [31:0] stk_addr_o,
    input wire stk_ack_i,
    // flow and write-back
    input wire [31:0] pc_o,
    input wire [31:0] status_word_o,
    input wire branch_o,
    input wire illegal_slot_o,
    input wire exc_block_o,
    input wire wb_en_o,
    input wire [3:0] wb_idx_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    wire tk = issue_valid_i && issue_ready_o; // instruction taken
    wire tko = tk && !exc_block_o; // taken outside a slot
    wire [7:0] lo = issue_instr_i[7:0];
    wire multi = issue_instr_i[15:12] == `CRSE_SH_GROUP && (lo == `CRSE_SH_LOGIC_L2
        || lo == `CRSE_SH_LOGIC_L8 || lo == `CRSE_SH_LOGIC_L16);
    reg pop2_ff; // second pop pending
    // toggles on each answered pop
    always @(posedge clk_sys_i) begin
        if (!rstn_i) pop2_ff <= 1'b0;
        else if (stk_req_o && stk_ack_i) pop2_ff <= ~pop2_ff;
    end
    chk_flag_set: assert property (
        tk && issue_instr_i == `CRSE_OP_SET_FLAG |=> status_word_o[`CRSE_T_BIT])
        else $error("set flag left t low");
    chk_sub_stall: assert property (
        tko && issue_instr_i == `CRSE_OP_SUB_RET |=> !issue_ready_o && exc_block_o
        ##1 issue_ready_o) else $error("subroutine return not two states");
    chk_exc_pop: assert property (
        tko && issue_instr_i == `CRSE_OP_EXC_RET |=> stk_req_o && !issue_ready_o
        ##[3:39] issue_ready_o) else $error("exception return sequence wrong");
    chk_pop_step: assert property (
        stk_req_o && stk_ack_i && !pop2_ff |=> stk_req_o
        && stk_addr_o == $past(stk_addr_o) + `CRSE_STACK_STEP)
        else $error("second pop address wrong");
    chk_req_hold: assert property (
        stk_req_o && !stk_ack_i |=> stk_req_o && $stable(stk_addr_o))
        else $error("stack request dropped");
    chk_pop_mask: assert property (
        stk_req_o && stk_ack_i && pop2_ff |=> !stk_req_o
        && (status_word_o & ~`CRSE_STATUS_MASK) == 32'h00000000)
        else $error("status not masked");
    chk_slot_branch: assert property (
        branch_o |-> !exc_block_o && $past(exc_block_o) && !illegal_slot_o)
        else $error("branch without slot");
    chk_illegal_br: assert property (
        tk && exc_block_o && issue_instr_i[15:12] == `CRSE_BR_REL_JUMP
        |=> illegal_slot_o && !branch_o && pc_o == $past(pc_o))
        else $error("slot branch not refused");
    chk_multi_keep: assert property (
        tk && multi |=> wb_en_o && wb_idx_o == $past(issue_instr_i[11:8])
        && status_word_o[0] == $past(status_word_o[0])) else $error("multi shift wrong");
    chk_pc_step: assert property (
        tko && multi |=> pc_o == $past(pc_o) + `CRSE_INSTR_STEP)
        else $error("pc step wrong");
    cover property (tko && issue_instr_i == `CRSE_OP_EXC_RET);
    cover property (branch_o);
    cover property (illegal_slot_o);
endmodule // crse_top_sva
bind crse_top crse_top_sva i_sva (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .issue_valid_i(issue_valid_i), .issue_instr_i(issue_instr_i),
    .issue_ready_o(issue_ready_o), .stk_req_o(stk_req_o), .stk_addr_o(stk_addr_o),
    .stk_ack_i(stk_ack_i), .pc_o(pc_o), .status_word_o(status_word_o),
    .branch_o(branch_o), .illegal_slot_o(illegal_slot_o),
    .exc_block_o(exc_block_o), .wb_en_o(wb_en_o), .wb_idx_o(wb_idx_o));

// *** cpu_return_and_shift_exec_tb_top.sv ***
// self-checking bench for the return and shift slice
`timescale 1ns/1ns
`include "crse_map.vh"
`define CHK(nm, e, g) begin samples_checked = samples_checked + 1; \
    if ((g) !== (e)) begin err_count = err_count + 1; \
    $display("unexpected %s exp %h seen %h", nm, e, g); end end
module cpu_return_and_shift_exec_tb_top;
    reg clk_sys_i, rstn_i, issue_valid_i, gpr_ld_en_i, link_ld_en_i, t_exp;
    reg [15:0] issue_instr_i;
    reg [3:0] gpr_ld_idx_i, mdl_wait;
    reg [31:0] gpr_ld_data_i, link_ld_data_i;
    wire issue_ready_o, stk_req_o, stk_ack_i, branch_o, illegal_slot_o;
    wire exc_block_o, wb_en_o;
    wire [31:0] stk_addr_o, stk_data_i, pc_o, status_word_o, wb_data_o;
    wire [3:0] wb_idx_o;
    integer err_count, samples_checked, cyc;
    crse_top i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .issue_valid_i(issue_valid_i), .issue_instr_i(issue_instr_i),
        .issue_ready_o(issue_ready_o), .stk_req_o(stk_req_o), .stk_addr_o(stk_addr_o),
        .stk_ack_i(stk_ack_i), .stk_data_i(stk_data_i), .gpr_ld_en_i(gpr_ld_en_i),
        .gpr_ld_idx_i(gpr_ld_idx_i), .gpr_ld_data_i(gpr_ld_data_i),
        .link_ld_en_i(link_ld_en_i), .link_ld_data_i(link_ld_data_i), .pc_o(pc_o),
        .status_word_o(status_word_o), .branch_o(branch_o),
        .illegal_slot_o(illegal_slot_o), .exc_block_o(exc_block_o),
        .wb_en_o(wb_en_o), .wb_idx_o(wb_idx_o), .wb_data_o(wb_data_o));
    crse_stack_model i_mem (.clk_sys_i(clk_sys_i), .req_i(stk_req_o),
        .addr_i(stk_addr_o), .wait_i(mdl_wait), .ack_o(stk_ack_i), .data_o(stk_data_i));
    // 125 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // offer one instruction, hold it until taken
    task issue(input [15:0] ins);
        integer n;
        begin
            @(negedge clk_sys_i);
            issue_valid_i = 1'b1;
            issue_instr_i = ins;
            n = 0;
            while (issue_ready_o !== 1'b1 && n < 60) begin
                @(negedge clk_sys_i);
                n = n + 1;
            end
            `CHK("issue ready", 1'b1, issue_ready_o)
            @(negedge clk_sys_i);
            issue_valid_i = 1'b0;
        end
    endtask
    // preload a general register
    task load(input [3:0] idx, input [31:0] v);
        begin
            @(negedge clk_sys_i);
            gpr_ld_en_i = 1'b1;
            gpr_ld_idx_i = idx;
            gpr_ld_data_i = v;
            @(negedge clk_sys_i);
            gpr_ld_en_i = 1'b0;
        end
    endtask
    // every shift on two opposite patterns
    task t_shifts;
        integer j, k;
        reg [31:0] v, e;
        reg [7:0] op;
        reg [55:0] tbl;
        begin
            tbl = {`CRSE_SH_LOGIC_L16, `CRSE_SH_LOGIC_R1, `CRSE_SH_LOGIC_L8,
                `CRSE_SH_ARITH_R1, `CRSE_SH_LOGIC_L2, `CRSE_SH_LOGIC_L1, `CRSE_SH_ARITH_L1};
            for (j = 0; j < 7; j = j + 1) begin
                for (k = 0; k < 2; k = k + 1) begin
                    v = k ? 32'h92345679 : 32'h6DCBA986;
                    op = tbl[8*j +: 8];
                    load(j[3:0], v);
                    issue({4'h4, j[3:0], op});
                    case (op)
                        `CRSE_SH_ARITH_L1, `CRSE_SH_LOGIC_L1: begin
                            e = v << 1;
                            t_exp = v[31];
                        end
                        `CRSE_SH_ARITH_R1: begin
                            e = {v[31], v[31:1]};
                            t_exp = v[0];
                        end
                        `CRSE_SH_LOGIC_R1: begin
                            e = v >> 1;
                            t_exp = v[0];
                        end
                        `CRSE_SH_LOGIC_L2: e = v << 2;
                        `CRSE_SH_LOGIC_L8: e = v << 8;
                        default: e = v << 16;
                    endcase
                    `CHK("shift result", e, wb_data_o)
                    `CHK("shift index", j[3:0], wb_idx_o)
                    `CHK("t flag", t_exp, status_word_o[0])
                end
            end
        end
    endtask
    // clear t, then set it
    task t_setflag;
        begin
            load(4'h1, 32'h00000002);
            issue(16'h4101);
            `CHK("t clear", 1'b0, status_word_o[0])
            issue(`CRSE_OP_SET_FLAG);
            `CHK("t set", 1'b1, status_word_o[0])
            `CHK("no write", 1'b0, wb_en_o)
        end
    endtask
    // link changed after the return must not move the target
    task t_sub_ret;
        begin
            load(4'h5, 32'h00000011);
            @(negedge clk_sys_i);
            link_ld_en_i = 1'b1;
            link_ld_data_i = 32'h00001234;
            @(negedge clk_sys_i);
            link_ld_en_i = 1'b0;
            issue(`CRSE_OP_SUB_RET);
            `CHK("block", 1'b1, exc_block_o)
            `CHK("stall", 1'b0, issue_ready_o)
            link_ld_en_i = 1'b1;
            link_ld_data_i = 32'h0000BEEF;
            @(negedge clk_sys_i);
            link_ld_en_i = 1'b0;
            issue(16'h4508);
            `CHK("branch", 1'b1, branch_o)
            `CHK("target", 32'h00001234, pc_o)
            `CHK("slot ran", 32'h00000044, wb_data_o)
            `CHK("unblock", 1'b0, exc_block_o)
        end
    endtask
    // pop pc and status with a given memory delay
    task t_exc_ret(input [3:0] w);
        reg [31:0] sp;
        begin
            sp = 32'h00000100;
            mdl_wait = w;
            load(`CRSE_SP_IDX, sp);
            issue(`CRSE_OP_EXC_RET);
            `CHK("pop addr", sp, stk_addr_o)
            `CHK("block", 1'b1, exc_block_o)
            issue(16'h4218);
            `CHK("branch", 1'b1, branch_o)
            `CHK("resume pc", sp ^ 32'hA5A5F3FF, pc_o)
            `CHK("status", ((sp + 32'h4) ^ 32'hA5A5F3FF) & `CRSE_STATUS_MASK, status_word_o)
            issue(16'h4F08);
            `CHK("sp after", (sp + 32'h8) << 2, wb_data_o)
        end
    endtask
    // branches in a slot are refused and pc holds
    task t_illegal;
        integer j;
        reg [127:0] tbl;
        reg [31:0] p;
        begin
            tbl = {16'h8905, 16'h8B10, 16'h4E2B, `CRSE_OP_EXC_RET, 16'hB123, 16'h4E0B,
                16'hA7FF, `CRSE_OP_SUB_RET};
            for (j = 0; j < 8; j = j + 1) begin
                issue(`CRSE_OP_SUB_RET);
                repeat (2) @(negedge clk_sys_i);
                p = pc_o;
                issue(tbl[16*j +: 16]);
                `CHK("illegal", 1'b1, illegal_slot_o)
                `CHK("no branch", 1'b0, branch_o)
                `CHK("pc held", p, pc_o)
                `CHK("unblock", 1'b0, exc_block_o)
            end
        end
    endtask
    // reset in mid-run
    task t_reset;
        begin
            @(negedge clk_sys_i);
            rstn_i = 1'b0;
            repeat (2) @(negedge clk_sys_i);
            `CHK("pc reset", 32'h00000000, pc_o)
            `CHK("status reset", 32'h00000000, status_word_o)
            rstn_i = 1'b1;
        end
    endtask
    // verdict and end of run
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    // hang guard
    always @(posedge clk_sys_i) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            tally_and_finish;
        end
    end
    // main sequence
    initial begin
        err_count = 0;
        samples_checked = 0;
        cyc = 0;
        rstn_i = 1'b0;
        {issue_valid_i, gpr_ld_en_i, link_ld_en_i, t_exp} = 4'h0;
        issue_instr_i = 16'h0000;
        {gpr_ld_idx_i, mdl_wait} = 8'h00;
        gpr_ld_data_i = 32'h00000000;
        link_ld_data_i = 32'h00000000;
        repeat (8) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rstn_i = 1'b1;
        t_shifts;
        t_setflag;
        t_sub_ret;
        t_exc_ret(4'h0);
        t_reset;
        t_exc_ret(4'h3);
        t_illegal;
        tally_and_finish;
    end
endmodule // cpu_return_and_shift_exec_tb_top
